// *** tb_uart_mode_control.sv ***
// Self-checking bench for the serial port mode control
`timescale 1ns/10ps
module tb_uart_mode_control;
  logic               clk = 1'b0, rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
  logic               idle_mode = 1'b0, sleep_mode = 1'b0, baud16_tick = 1'b0;
  logic               core_tx = 1'b1, core_tx_busy = 1'b1, core_rx_ready = 1'b0;
  logic               core_bclk = 1'b0, irq, core_rx, core_cts_n, core_run, core_rx_hold;
  logic               rx_line, cts_line;
  logic [1:0]         reg_addr = 2'h0;
  logic [15:0]        reg_wdata = 16'h0000, reg_rdata;
  umc_pkg::umc_pins_t latch_pins = 6'h26, pins;
  int                 num_errors = 0, checks = 0;
  umc_mode_control umc_mode_control_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re,
    .reg_rdata, .irq, .idle_mode, .sleep_mode, .baud16_tick, .core_tx, .core_tx_busy,
    .core_rx_ready, .core_bclk, .core_rx, .core_cts_n, .core_run, .core_rx_hold,
    .latch_pins, .pins, .rx_line, .cts_line);
  umc_serial_peer umc_serial_peer_i (.clk, .rx_line, .cts_line);
  // 20 MHz system clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Baud clock toggles each rising edge so the clock pin check sees real motion
  always @(posedge clk) begin
    core_bclk   <= ~core_bclk;
    baud16_tick <= core_bclk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk);
    reg_we    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rc(input logic [1:0] a, input logic [15:0] e, input string n);
    @(posedge clk);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk);
    reg_re   <= 1'b0;
    @(negedge clk);
    chk(n, e, reg_rdata);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wait_irq();
    for (int i = 0; i < 200 && irq !== 1'b1; i++) @(negedge clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic t_regs();
    for (int a = 0; a < 4; a++) rc(2'(a), 16'h0000, "reset value");
    chk("pins off", 16'(latch_pins), 16'(pins));
    wr(umc_pkg::ADDR_MODE, 16'hffff);
    rc(umc_pkg::ADDR_MODE, 16'hbbff, "mode fields");
    chk("rate hold", 16'h0001, 16'(core_rx_hold));
    wr(umc_pkg::ADDR_RATE, 16'hffff);
    rc(umc_pkg::ADDR_RATE, 16'h0000, "rate read only");
    wr(umc_pkg::ADDR_MODE, 16'h0000);
  endtask
  // Every pin-usage code with simplex request, then flow style, then off
  task automatic t_pins();
    umc_pkg::umc_pins_t e;
    for (int u = 0; u < 4; u++) begin
      wr(umc_pkg::ADDR_MODE, 16'h8800 | 16'(u << 8));
      settle(1);
      e = latch_pins;
      e.tx = '{1'b1, 1'b1};
      if (u == 1 || u == 2) e.rts = '{1'b0, 1'b1};
      if (u == 3) e.rts = '{~core_bclk, 1'b1};
      if (u == 2) e.cts = '{1'b0, 1'b0};
      chk("tx pin", 16'(e.tx), 16'(pins.tx));
      chk("rts pin", 16'(e.rts), 16'(pins.rts));
      chk("cts pin", 16'(e.cts), 16'(pins.cts));
      chk("cts seen", 16'(u == 2), 16'(core_cts_n));
    end
    wr(umc_pkg::ADDR_MODE, 16'h8100);
    settle(1);
    chk("rts flow", 16'h0001, 16'(pins.rts.out));
    wr(umc_pkg::ADDR_MODE, 16'h0000);
    latch_pins <= umc_pkg::umc_pins_t'(6'h19);
    settle(1);
    chk("pins off", 16'h0019, 16'(pins));
  endtask
  // Halt in idle, loopback, then the infrared encoder in both rate modes
  task automatic t_modes();
    wr(umc_pkg::ADDR_MODE, 16'ha000);
    idle_mode <= 1'b1;
    settle(1);
    chk("run halted", 16'h0000, 16'(core_run));
    wr(umc_pkg::ADDR_MODE, 16'h8040);
    core_tx <= 1'b0;
    settle(6);
    chk("run in idle", 16'h0001, 16'(core_run));
    chk("loop rx", 16'h0000, 16'(core_rx));
    chk("loop tx pin", 16'h0001, 16'(pins.tx.out));
    wr(umc_pkg::ADDR_MODE, 16'h9000);
    idle_mode <= 1'b0;
    core_tx <= 1'b1;
    settle(2);
    chk("ir idle", 16'h0000, 16'(pins.tx.out));
    // A zero bit gives a short pulse at its head, then the pin falls back low
    @(posedge clk);
    core_tx <= 1'b0;
    settle(3);
    chk("ir pulse", 16'h0001, 16'(pins.tx.out));
    settle(12);
    chk("ir gap", 16'h0000, 16'(pins.tx.out));
    wr(umc_pkg::ADDR_MODE, 16'h9008);
    core_tx <= 1'b1;
    settle(2);
    chk("ir fast", 16'h0001, 16'(pins.tx.out));
  endtask
  task automatic t_wake();
    wr(umc_pkg::ADDR_MASK, 16'h0001);
    wr(umc_pkg::ADDR_MODE, 16'h8080);
    sleep_mode <= 1'b1;
    umc_serial_peer_i.drive(1'b0);
    wait_irq();
    chk("wake irq", 16'h0001, 16'(irq));
    rc(umc_pkg::ADDR_STATUS, 16'h0001, "wake status");
    umc_serial_peer_i.drive(1'b1);
    settle(8);
    rc(umc_pkg::ADDR_MODE, 16'h8000, "wake clear");
    wr(umc_pkg::ADDR_MASK, 16'h0000);
    settle(0);
    chk("masked irq", 16'h0000, 16'(irq));
    wr(umc_pkg::ADDR_STATUS, 16'h0001);
    wr(umc_pkg::ADDR_MASK, 16'h0001);
    sleep_mode <= 1'b0;
    settle(0);
    chk("cleared irq", 16'h0000, 16'(irq));
  endtask
  // Sync field at 16 clocks a bit: five falls span eight bit times
  task automatic t_rate();
    wr(umc_pkg::ADDR_MASK, 16'h0002);
    wr(umc_pkg::ADDR_MODE, 16'h8020);
    umc_serial_peer_i.send(8'h55, 16);
    wait_irq();
    rc(umc_pkg::ADDR_RATE, 16'h0080, "rate count");
    rc(umc_pkg::ADDR_MODE, 16'h8000, "rate clear");
    rc(umc_pkg::ADDR_STATUS, 16'h0002, "rate status");
  endtask
  // Reset for three clocks, then each scenario in turn
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_pins();
    t_modes();
    t_wake();
    t_rate();
    give_verdict();
  end
  // The sequence needs under 1000 clocks; stop a hang well beyond that
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    give_verdict();
  end
endmodule

// *** umc_mode_control.sv ***
// Mode and control register logic for the asynchronous serial port
`timescale 1ns/10ps
module umc_mode_control (
  input  wire logic                clk,           // System clock, 20 MHz
  input  wire logic                rst,           // Asynchronous reset, active high
  input  wire logic [1:0]          reg_addr,      // Register word address
  input  wire logic [15:0]         reg_wdata,     // Register write data
  input  wire logic                reg_we,        // Write strobe
  input  wire logic                reg_re,        // Read strobe
  output logic      [15:0]         reg_rdata,     // Read data, cycle after strobe
  output logic                     irq,           // Level interrupt
  input  wire logic                idle_mode,     // Device in idle
  input  wire logic                sleep_mode,    // Device in sleep
  input  wire logic                baud16_tick,   // 16x baud enable pulse
  input  wire logic                core_tx,       // Serial data from transmitter
  input  wire logic                core_tx_busy,  // Transmitter has data to send
  input  wire logic                core_rx_ready, // Receiver can accept data
  input  wire logic                core_bclk,     // Baud clock from generator
  output logic                     core_rx,       // Serial data to receiver
  output logic                     core_cts_n,    // Clear to send seen by transmitter
  output logic                     core_run,      // Serial engine may operate
  output logic                     core_rx_hold,  // Receiver ignores line while measuring
  input  wire umc_pkg::umc_pins_t  latch_pins,    // Port latch drive
  output umc_pkg::umc_pins_t       pins,          // Drive of the three shared pins
  input  wire logic                rx_line,       // Receive pin
  input  wire logic                cts_line       // Clear to send pin, active low
);

  typedef enum {AB_IDLE, AB_COUNT} umc_ab_state_t;
  logic [15:0]                    mode_q;
  logic [umc_pkg::EVT_COUNT-1:0]  status_q;
  logic [umc_pkg::EVT_COUNT-1:0]  mask_q;
  logic [15:0]                    rate_q;
  logic [15:0]                    rdata_q;
  logic [15:0]                    ab_cnt_q;
  logic [2:0]                     ab_edges_q;
  umc_ab_state_t                  ab_state_q;
  logic                           wake_seen_q;
  logic [3:0]                     ir_tx_ph_q;
  logic                           ir_tx_prev_q;
  logic                           ir_tx_q;
  logic [3:0]                     ir_rx_ph_q;
  logic                           ir_rx_q;
  logic                           rx_prev_q;
  logic [umc_pkg::SYNC_STAGES-1:0] sync_q [2];
  logic [1:0]                     filt_q;
  umc_pkg::umc_pins_t             pins_q;
  logic                           core_rx_q;
  logic                           core_cts_n_q;
  logic        module_on;
  logic        active;
  logic        ir_active;
  logic [1:0]  usage;
  logic        rx_clean;
  logic        rx_level;
  logic        rx_fall;
  logic        rx_rise;
  logic        tx_drive;
  logic        rts_drive;
  logic        ab_done;
  logic        wake_event;
  logic        hw_clear_wake;
  logic        mode_wr;

  // Decode of a register strobe against one address
  function automatic logic umc_hit(input logic strobe, input logic [1:0] addr,
                                   input logic [1:0] target);
    umc_hit = strobe && (addr == target);
  endfunction

  assign module_on = mode_q[umc_pkg::BIT_MODULE_ON];
  assign usage     = mode_q[umc_pkg::BIT_USAGE_HI:umc_pkg::BIT_USAGE_LO];
  assign mode_wr   = umc_hit(reg_we, reg_addr, umc_pkg::ADDR_MODE);

  // Engine runs only when on and not parked by idle
  assign active = module_on && !(mode_q[umc_pkg::BIT_HALT_IDLE] && idle_mode);

  // Infrared shaping is refused in 4x rate mode even if requested
  assign ir_active = active && mode_q[umc_pkg::BIT_IR_ON] &&
                     !mode_q[umc_pkg::BIT_HIGH_SPEED];

  // Pin synchronisers: three stages, a change counts once the last two agree
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_sync
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sync_q[g] <= '1;
          filt_q[g] <= 1'b1;
        end else begin
          sync_q[g] <= {sync_q[g][umc_pkg::SYNC_STAGES-2:0], (g == 0) ? rx_line : cts_line};
          if (sync_q[g][1] == sync_q[g][2]) begin
            filt_q[g] <= sync_q[g][2];
          end
        end
      end
    end
  endgenerate

  // Receive line as the engine sees it: loopback, then decoder, then polarity
  always_comb begin
    rx_level = filt_q[0];
    if (mode_q[umc_pkg::BIT_LOOPBACK]) begin
      rx_level = core_tx;
    end else if (ir_active) begin
      rx_level = ir_rx_q;
    end
    rx_clean = rx_level ^ mode_q[umc_pkg::BIT_RX_INVERT];
  end

  assign rx_fall = rx_prev_q && !rx_clean;
  assign rx_rise = !rx_prev_q && rx_clean;

  // Edge history of the cleaned receive line
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_clean;
    end
  end

  // Infrared encoder: a short high pulse at the head of each zero bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_tx_ph_q   <= 4'h0;
      ir_tx_prev_q <= 1'b1;
      ir_tx_q      <= 1'b0;
    end else if (!ir_active) begin
      ir_tx_ph_q   <= 4'h0;
      ir_tx_prev_q <= 1'b1;
      ir_tx_q      <= 1'b0;
    end else begin
      ir_tx_prev_q <= core_tx;
      if (ir_tx_prev_q && !core_tx) begin
        ir_tx_ph_q <= 4'h0; // Realign phase to the start edge
      end else if (baud16_tick) begin
        ir_tx_ph_q <= ir_tx_ph_q + 4'h1;
      end
      ir_tx_q <= !core_tx && (ir_tx_ph_q < umc_pkg::IR_PULSE_TICKS);
    end
  end

  // Infrared decoder: a received pulse stretches to a full low bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ir_rx_ph_q <= 4'h0;
      ir_rx_q    <= 1'b1;
    end else if (!ir_active) begin
      ir_rx_ph_q <= 4'h0;
      ir_rx_q    <= 1'b1;
    end else if (filt_q[0]) begin
      ir_rx_ph_q <= 4'h0;
      ir_rx_q    <= 1'b0;
    end else if (!ir_rx_q && baud16_tick) begin
      if (ir_rx_ph_q == umc_pkg::IR_BIT_LAST) begin
        ir_rx_q <= 1'b1;
      end
      ir_rx_ph_q <= ir_rx_ph_q + 4'h1;
    end
  end

  // Auto rate: time from start edge to the fifth falling edge of 55h
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ab_state_q <= AB_IDLE;
      ab_cnt_q   <= 16'h0000;
      ab_edges_q <= 3'h0;
      rate_q     <= umc_pkg::RATE_RESET;
    end else begin
      case (ab_state_q)
        AB_IDLE: begin
          if (active && mode_q[umc_pkg::BIT_AUTO_RATE] && rx_fall) begin
            ab_state_q <= AB_COUNT;
            ab_cnt_q   <= 16'h0001;
            ab_edges_q <= 3'h0;
          end
        end
        AB_COUNT: begin
          if (!active || !mode_q[umc_pkg::BIT_AUTO_RATE]) begin
            ab_state_q <= AB_IDLE; // Abandoned by software or shutdown
          end else if (rx_fall && ab_edges_q == umc_pkg::SYNC_EDGES - 3'h1) begin
            ab_state_q <= AB_IDLE;
            rate_q     <= ab_cnt_q;
          end else begin
            if (rx_fall) begin
              ab_edges_q <= ab_edges_q + 3'h1;
            end
            if (ab_cnt_q != 16'hffff) begin
              ab_cnt_q <= ab_cnt_q + 16'h0001; // Saturate on a line that never toggles
            end
          end
        end
        default: ab_state_q <= AB_IDLE;
      endcase
    end
  end

  assign ab_done = (ab_state_q == AB_COUNT) && active && mode_q[umc_pkg::BIT_AUTO_RATE] &&
                   rx_fall && (ab_edges_q == umc_pkg::SYNC_EDGES - 3'h1);
  assign core_rx_hold = mode_q[umc_pkg::BIT_AUTO_RATE];

  // Wake: falling edge in sleep raises the event, the next rise drops the control
  assign wake_event    = mode_q[umc_pkg::BIT_WAKE] && sleep_mode && !wake_seen_q && rx_fall;
  assign hw_clear_wake = mode_q[umc_pkg::BIT_WAKE] && wake_seen_q && rx_rise;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_seen_q <= 1'b0;
    end else if (!mode_q[umc_pkg::BIT_WAKE] || hw_clear_wake) begin
      wake_seen_q <= 1'b0;
    end else if (wake_event) begin
      wake_seen_q <= 1'b1;
    end
  end

  // Mode register; a software write in the same cycle beats a hardware clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= umc_pkg::MODE_RESET;
    end else if (mode_wr) begin
      mode_q <= reg_wdata & umc_pkg::MODE_WRITE_MASK;
    end else begin
      if (hw_clear_wake) begin
        mode_q[umc_pkg::BIT_WAKE] <= 1'b0;
      end
      if (ab_done) begin
        mode_q[umc_pkg::BIT_AUTO_RATE] <= 1'b0;
      end
    end
  end

  // Sticky events: a new event wins over a write-one clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= umc_pkg::EVT_RESET;
    end else begin
      for (int i = 0; i < umc_pkg::EVT_COUNT; i++) begin
        if ((i == umc_pkg::EVT_WAKE && wake_event) ||
            (i == umc_pkg::EVT_RATE_DONE && ab_done)) begin
          status_q[i] <= 1'b1;
        end else if (umc_hit(reg_we, reg_addr, umc_pkg::ADDR_STATUS) && reg_wdata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_q <= umc_pkg::EVT_RESET;
    end else if (umc_hit(reg_we, reg_addr, umc_pkg::ADDR_MASK)) begin
      mask_q <= reg_wdata[umc_pkg::EVT_COUNT-1:0];
    end
  end

  assign irq = |(status_q & mask_q);

  // Read port; data stands only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (reg_re) begin
      case (reg_addr)
        umc_pkg::ADDR_MODE:   rdata_q <= mode_q & umc_pkg::MODE_WRITE_MASK;
        umc_pkg::ADDR_STATUS: rdata_q <= {14'h0000, status_q};
        umc_pkg::ADDR_MASK:   rdata_q <= {14'h0000, mask_q};
        umc_pkg::ADDR_RATE:   rdata_q <= rate_q;
        default:              rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign reg_rdata = rdata_q;

  // Transmit pin idles high in loopback so the partner sees nothing
  assign tx_drive = mode_q[umc_pkg::BIT_LOOPBACK] ? 1'b1 :
                    (ir_active ? ir_tx_q : core_tx);

  // Request pin: simplex signals a pending send, flow control signals room
  assign rts_drive = mode_q[umc_pkg::BIT_RTS_STYLE] ? !core_tx_busy :
                     !core_rx_ready;

  // Pin ownership by usage code; port latches keep whatever the port gives up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_q <= '0;
    end else begin
      pins_q <= latch_pins;
      if (module_on) begin
        pins_q.tx <= '{out: tx_drive, oe: 1'b1};
        case (usage)
          umc_pkg::USAGE_TX_RX:      pins_q.rts <= latch_pins.rts;
          umc_pkg::USAGE_WITH_RTS:   pins_q.rts <= '{out: rts_drive, oe: 1'b1};
          umc_pkg::USAGE_FULL_HS: begin
            pins_q.rts <= '{out: rts_drive, oe: 1'b1};
            pins_q.cts <= '{out: 1'b0, oe: 1'b0};
          end
          umc_pkg::USAGE_BAUD_CLOCK: pins_q.rts <= '{out: core_bclk, oe: 1'b1};
          default: pins_q.rts <= latch_pins.rts;
        endcase
      end
    end
  end
  assign pins = pins_q;

  // Engine side inputs; clear to send counts only when its pin is in use
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_rx_q    <= 1'b1;
      core_cts_n_q <= 1'b0;
    end else begin
      core_rx_q    <= active ? rx_clean : 1'b1;
      core_cts_n_q <= (module_on && usage == umc_pkg::USAGE_FULL_HS &&
                       !mode_q[umc_pkg::BIT_LOOPBACK]) ? filt_q[1] : 1'b0;
    end
  end

  assign core_rx    = core_rx_q;
  assign core_cts_n = core_cts_n_q;
  assign core_run   = active;

endmodule

// *** umc_mode_control_checker.sv ***
// Port assertions for the serial port mode control
`timescale 1ns/10ps
module umc_checker (
  input wire logic               clk,          // Clock
  input wire logic               rst,          // Reset
  input wire logic [1:0]         reg_addr,     // Address
  input wire logic [15:0]        reg_wdata,    // Write data
  input wire logic               reg_we,       // Write strobe
  input wire logic               reg_re,       // Read strobe
  input wire logic [15:0]        reg_rdata,    // Read data
  input wire logic               irq,          // Interrupt
  input wire logic               idle_mode,    // Idle
  input wire logic               core_tx_busy, // Data to send
  input wire logic               core_run,     // Engine enable
  input wire logic               core_rx_hold, // Rate hold
  input wire umc_pkg::umc_pins_t latch_pins,   // Latch drive
  input wire umc_pkg::umc_pins_t pins          // Pin drive
);
  logic [15:0] sh_q;   // Mode bits as last written
  logic        live_q; // Set one edge after reset so $past sees run values
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Shadow skips hardware clears, so only bits without them are judged
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_q   <= 16'h0000;
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
      if (reg_we && reg_addr == umc_pkg::ADDR_MODE) begin
        sh_q <= reg_wdata & umc_pkg::MODE_WRITE_MASK;
      end
    end
  end
  // Module on with a given pin-usage code at the previous edge
  sequence used_as(logic [1:0] u);
    live_q && $past(sh_q[umc_pkg::BIT_MODULE_ON] &&
                    sh_q[umc_pkg::BIT_USAGE_HI:umc_pkg::BIT_USAGE_LO] == u);
  endsequence
  sequence mode_read;
    reg_re && reg_addr == umc_pkg::ADDR_MODE;
  endsequence
  off_pins_a: assert property (
    live_q && !$past(sh_q[umc_pkg::BIT_MODULE_ON]) |-> pins == $past(latch_pins))
    else $error("pins not on latches while off");
  tx_drive_a: assert property (
    live_q && $past(sh_q[umc_pkg::BIT_MODULE_ON]) |-> pins.tx.oe)
    else $error("tx pin not driven while on");
  plain_pins_a: assert property (
    used_as(umc_pkg::USAGE_TX_RX) |->
      pins.rts == $past(latch_pins.rts) && pins.cts == $past(latch_pins.cts))
    else $error("handshake pins not on latches");
  rts_style_a: assert property (
    used_as(umc_pkg::USAGE_WITH_RTS) ##0 $past(sh_q[umc_pkg::BIT_RTS_STYLE]) |->
      pins.rts.out == !$past(core_tx_busy))
    else $error("simplex request pin wrong");
  cts_input_a: assert property (
    used_as(umc_pkg::USAGE_FULL_HS) |-> !pins.cts.oe && pins.rts.oe)
    else $error("full handshake pins wrong");
  idle_halt_a: assert property (
    core_run == (sh_q[umc_pkg::BIT_MODULE_ON] &&
                 !(sh_q[umc_pkg::BIT_HALT_IDLE] && idle_mode)))
    else $error("run enable wrong");
  loop_tx_a: assert property (
    live_q && $past(sh_q[umc_pkg::BIT_MODULE_ON] && sh_q[umc_pkg::BIT_LOOPBACK]) |->
      pins.tx.out)
    else $error("tx pin not idle in loopback");
  hidden_bits_a: assert property (
    mode_read |=> reg_rdata[14] == 1'b0 && reg_rdata[10] == 1'b0)
    else $error("absent mode bits read nonzero");
  rate_arm_a: assert property (
    $rose(core_rx_hold) |->
      $past(reg_we && reg_addr == umc_pkg::ADDR_MODE && reg_wdata[umc_pkg::BIT_AUTO_RATE]))
    else $error("rate hold rose without a write");
  mask_off_a: assert property (
    reg_we && reg_addr == umc_pkg::ADDR_MASK &&
      reg_wdata[umc_pkg::EVT_COUNT-1:0] == umc_pkg::EVT_RESET |=> !irq)
    else $error("interrupt high with all masked");
endmodule
bind umc_mode_control umc_checker umc_checker_i (.clk, .rst, .reg_addr, .reg_wdata, .reg_we,
  .reg_re, .reg_rdata, .irq, .idle_mode, .core_tx_busy, .core_run, .core_rx_hold,
  .latch_pins, .pins);

// *** umc_pkg.sv ***
// Shared constants, field positions and carrier types for the serial port mode control
package umc_pkg;

  // Register word offsets on the plain register port
  localparam logic [1:0] ADDR_MODE   = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_MASK   = 2'h2;
  localparam logic [1:0] ADDR_RATE   = 2'h3;

  // Mode register field positions
  localparam int BIT_MODULE_ON   = 15;
  localparam int BIT_HALT_IDLE   = 13;
  localparam int BIT_IR_ON       = 12;
  localparam int BIT_RTS_STYLE   = 11;
  localparam int BIT_USAGE_HI    = 9;
  localparam int BIT_USAGE_LO    = 8;
  localparam int BIT_WAKE        = 7;
  localparam int BIT_LOOPBACK    = 6;
  localparam int BIT_AUTO_RATE   = 5;
  localparam int BIT_RX_INVERT   = 4;
  localparam int BIT_HIGH_SPEED  = 3;
  localparam int BIT_PARITY_HI   = 2;
  localparam int BIT_PARITY_LO   = 1;
  localparam int BIT_STOP_COUNT  = 0;

  // Writable positions of the mode register; bits 14 and 10 are absent
  localparam logic [15:0] MODE_WRITE_MASK = 16'hbbff;
  localparam logic [15:0] MODE_RESET      = 16'h0000;

  // Interrupt status and mask layout
  localparam int EVT_WAKE       = 0;
  localparam int EVT_RATE_DONE  = 1;
  localparam int EVT_COUNT      = 2;
  localparam logic [EVT_COUNT-1:0] EVT_RESET = 2'h0;

  // Pin-usage codes
  localparam logic [1:0] USAGE_TX_RX      = 2'h0;
  localparam logic [1:0] USAGE_WITH_RTS   = 2'h1;
  localparam logic [1:0] USAGE_FULL_HS    = 2'h2;
  localparam logic [1:0] USAGE_BAUD_CLOCK = 2'h3;

  // Infrared pulse shape, in 16x baud ticks
  localparam logic [3:0] IR_PULSE_TICKS = 4'h3;
  localparam logic [3:0] IR_BIT_LAST    = 4'hf;

  // Falling edges of a 55h sync field after the start edge: spans eight bit times
  localparam logic [2:0] SYNC_EDGES = 3'h4;
  localparam logic [15:0] RATE_RESET = 16'h0000;

  // Synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 3;

  // One two-way pin seen from the block
  typedef struct packed {
    logic out;
    logic oe;
  } umc_pin_t;

  // Port latch drive for the three shared pins
  typedef struct packed {
    umc_pin_t tx;
    umc_pin_t rts;
    umc_pin_t cts;
  } umc_pins_t;

endpackage

// *** umc_serial_peer.sv ***
// Far-side serial device driving the receive and clear-to-send lines
`timescale 1ns/10ps
module umc_serial_peer (
  input  wire logic clk,      // System clock
  output logic      rx_line,  // Serial data into the port
  output logic      cts_line  // Clear to send, active low
);
  // Line rests high as behind a pull-up; clear-to-send is never granted
  initial begin
    rx_line  = 1'b1;
    cts_line = 1'b1;
  end
  // Hold the line at one level from the next edge on
  task automatic drive(input logic v);
    @(posedge clk);
    rx_line <= v;
  endtask
  // Start bit, data low bit first, stop bit; one frame per call, no sync added
  task automatic send(input logic [7:0] b, input int bit_clks);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      drive(fr[i]);
      repeat (bit_clks - 1) @(posedge clk);
    end
  endtask
endmodule

// *** umc_tb_placeholder_none.sv ***
// Empty unit; the block needs no further source here
`timescale 1ns/10ps
